// ===== logic/dtc_top.sv
// dual timer/counter with mode register, run control and overflow interrupt
//
// How it works
// R1: a timer counts while its run bit is set and holds its count while it is clear.
// R2: with gate enable set a timer advances only while its gate pin is high and its run bit is set.
// R3: in gated counter operation each falling count pin edge counts while gate is high and run is set.
// R4: the source select bit picks external pin events (1) or machine cycles (0).
// R5: each timer has a 2-bit mode field, timer one in the upper nibble, timer zero in the lower.
// R6: mode 0 is a 13-bit counter, 5 bits in the low byte, 8 in the high, low byte top 3 bits zero.
// R7: mode 2 increments the low byte while the high byte holds the reload value untouched.
// R8: on a mode 2 low byte overflow the reload value is copied into the low byte.
// R9: timer one in split mode stops and keeps its value.
// R10: timer zero in split mode works as two independent 8-bit counters.
// R11: the split low byte obeys timer zero run and gate and sets the timer zero overflow flag.
// R12: the split high byte runs on timer one run bit and sets the timer one overflow flag.
// R13: software must not put timer zero in mode 2 while timer one is in mode 0 or 1.
// R14: timer operation advances once per machine cycle of 12 core clocks.
// R15: a count pin falling edge takes two machine cycles to detect, so half rate at most.
// R16: overflow flags are set by hardware, cleared by software or by interrupt acknowledge.
// R17: reset clears the mode register, run bits and overflow flags, leaving stopped timers in mode 0.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output var  logic [7:0] rd_data,
   input  wire logic       count_pin_zero,
   input  wire logic       count_pin_one,
   input  wire logic       gate_pin_zero,
   input  wire logic       gate_pin_one,
   input  wire logic       int_ack_zero,
   input  wire logic       int_ack_one,
   output var  logic       overflow_flag_zero,
   output var  logic       overflow_flag_one,
   output var  logic       irq
);

   // mode field decode, used for both timers
   function automatic dtc_pkg::dtc_mode_t mode_of(input logic [3:0] nib);
      mode_of = dtc_pkg::dtc_mode_t'(nib[dtc_pkg::FLD_MODE +: 2]);
   endfunction

   // one advance of a timer: returns {overflow, high, low}
   function automatic logic [16:0] step_count(
      input dtc_pkg::dtc_mode_t m,
      input logic [7:0]         lo,
      input logic [7:0]         hi
   );
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0]  c8;
      c13 = 14'h0000;
      c16 = 17'h00000;
      c8  = 9'h000;
      step_count = {1'b0, hi, lo};
      unique case (m)
         dtc_pkg::DTC_MODE_13: begin
            // see R6
            c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
            step_count = {c13[13], c13[12:5], 3'h0, c13[4:0]};
         end
         dtc_pkg::DTC_MODE_16: begin
            c16 = {1'b0, hi, lo} + 17'h00001;
            step_count = c16;
         end
         dtc_pkg::DTC_MODE_RLD: begin
            // see R7, R8
            c8 = {1'b0, lo} + 9'h001;
            step_count = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
         end
         dtc_pkg::DTC_MODE_SPLIT: begin
            // see R10, R11
            c8 = {1'b0, lo} + 9'h001;
            step_count = {c8[8], hi, c8[7:0]};
         end
      endcase
   endfunction

   logic [3:0] mach_cnt_ff;
   logic       mach_tick;
   logic [7:0] mode_ff;
   logic       run0_ff;
   logic       run1_ff;
   logic       ovf0_ff;
   logic       ovf1_ff;
   logic [7:0] lo_ff [2];
   logic [7:0] hi_ff [2];
   logic [1:0] irq_stat_ff;
   logic [1:0] irq_mask_ff;
   logic [7:0] rd_data_ff;
   logic       irq_ff;

   logic [3:0] pins_s;
   logic [7:0] nxt_lo [2];
   logic [7:0] nxt_hi [2];
   logic       cnt_ovf [2];
   logic       adv [2];
   logic       split0;
   logic       split1;
   logic       split_hi_adv;
   logic       split_hi_ovf;
   logic       evt_ovf0;
   logic       evt_ovf1;
   logic       run_wr;
   logic       nxt_ovf0;
   logic       nxt_ovf1;
   logic [1:0] nxt_irq_stat;
   logic [7:0] rd_mux;

   dtc_pkg::dtc_mode_t mode0;
   dtc_pkg::dtc_mode_t mode1;

   dtc_cnt_if cif0 ();
   dtc_cnt_if cif1 ();

   // see R5
   assign mode0  = mode_of(mode_ff[dtc_pkg::NIB_T0 +: 4]);
   assign mode1  = mode_of(mode_ff[dtc_pkg::NIB_T1 +: 4]);
   assign split0 = (mode0 == dtc_pkg::DTC_MODE_SPLIT);
   assign split1 = (mode1 == dtc_pkg::DTC_MODE_SPLIT);

   // machine cycle prescaler
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mach_cnt_ff <= dtc_pkg::RST_MACH;
      end else if (ce) begin
         if (mach_cnt_ff == dtc_pkg::MACH_LAST) begin
            mach_cnt_ff <= dtc_pkg::RST_MACH;
         end else begin
            mach_cnt_ff <= mach_cnt_ff + 4'h1;
         end
      end
   end

   assign mach_tick = (mach_cnt_ff == dtc_pkg::MACH_LAST);   // see R14

   // pins come from outside the clock domain
   dtc_sync #(
      .W (4)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .d     ({gate_pin_one, gate_pin_zero, count_pin_one, count_pin_zero}),
      .q     (pins_s)
   );

   // count request for timer zero (also the split low byte)
   assign cif0.mach_tick   = mach_tick;
   assign cif0.run         = run0_ff;                                   // see R1, R11
   assign cif0.gate_en     = mode_ff[dtc_pkg::NIB_T0 + dtc_pkg::FLD_GATE];
   assign cif0.src_ext     = mode_ff[dtc_pkg::NIB_T0 + dtc_pkg::FLD_SRC];
   assign cif0.count_pin_s = pins_s[0];
   assign cif0.gate_pin_s  = pins_s[2];

   // count request for timer one
   assign cif1.mach_tick   = mach_tick;
   assign cif1.run         = run1_ff;                                   // see R1
   assign cif1.gate_en     = mode_ff[dtc_pkg::NIB_T1 + dtc_pkg::FLD_GATE];
   assign cif1.src_ext     = mode_ff[dtc_pkg::NIB_T1 + dtc_pkg::FLD_SRC];
   assign cif1.count_pin_s = pins_s[1];
   assign cif1.gate_pin_s  = pins_s[3];

   dtc_cnt_gate u_gate0 (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .u     (cif0)
   );

   dtc_cnt_gate u_gate1 (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .u     (cif1)
   );

   assign adv[0] = cif0.advance;
   assign adv[1] = cif1.advance & ~split1;                               // see R9

   // split high byte counts machine cycles under timer one run bit only
   assign split_hi_adv = split0 & mach_tick & run1_ff;                   // see R12
   assign split_hi_ovf = split_hi_adv & (hi_ff[0] == 8'hFF);

   // next value of each timer; a software write to a byte wins over counting
   generate
      for (genvar g = 0; g < 2; g++) begin : g_tmr
         localparam logic [3:0] LO_OFS = (g == 0) ? dtc_pkg::OFS_LO_ZERO : dtc_pkg::OFS_LO_ONE;
         localparam logic [3:0] HI_OFS = (g == 0) ? dtc_pkg::OFS_HI_ZERO : dtc_pkg::OFS_HI_ONE;
         dtc_pkg::dtc_mode_t m;
         logic [16:0]        step;

         assign m = (g == 0) ? mode0 : mode1;

         always_comb begin
            step       = step_count(m, lo_ff[g], hi_ff[g]);
            nxt_lo[g]  = lo_ff[g];
            nxt_hi[g]  = hi_ff[g];
            cnt_ovf[g] = 1'b0;
            if (adv[g]) begin
               nxt_lo[g]  = step[7:0];
               nxt_hi[g]  = step[15:8];
               cnt_ovf[g] = step[16];
            end
            if ((g == 0) && split_hi_adv) begin
               nxt_hi[g] = hi_ff[g] + 8'h01;                             // see R10, R12
            end
            if (wr_en && (addr == LO_OFS)) begin
               // low byte top bits cannot hold ones in 13-bit mode
               nxt_lo[g] = (m == dtc_pkg::DTC_MODE_13) ? (wr_data & dtc_pkg::LOW13_MASK) : wr_data;   // see R6
            end
            if (wr_en && (addr == HI_OFS)) begin
               nxt_hi[g] = wr_data;                                      // see R7
            end
         end

         always_ff @(posedge clk) begin
            if (!rst_n) begin
               lo_ff[g] <= dtc_pkg::RST_BYTE;
               hi_ff[g] <= dtc_pkg::RST_BYTE;
            end else if (ce) begin
               lo_ff[g] <= nxt_lo[g];
               hi_ff[g] <= nxt_hi[g];
            end
         end
      end
   endgenerate

   // timer one loses its flag to the split high byte
   assign evt_ovf0 = cnt_ovf[0];                                         // see R11
   assign evt_ovf1 = split0 ? split_hi_ovf : cnt_ovf[1];                 // see R12

   // mode register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_ff <= dtc_pkg::RST_MODE;                                   // see R17
      end else if (ce && wr_en && (addr == dtc_pkg::OFS_MODE)) begin
         mode_ff <= wr_data;                                             // see R5
      end
   end

   // run bits
   assign run_wr = wr_en && (addr == dtc_pkg::OFS_RUN);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run0_ff <= 1'b0;                                                // see R17
         run1_ff <= 1'b0;
      end else if (ce && run_wr) begin
         run0_ff <= wr_data[dtc_pkg::RUN_RUN0_BIT];                      // see R1
         run1_ff <= wr_data[dtc_pkg::RUN_RUN1_BIT];
      end
   end

   // overflow flags: hardware set beats a software clear or an acknowledge
   always_comb begin
      nxt_ovf0 = ovf0_ff;
      nxt_ovf1 = ovf1_ff;
      if (run_wr) begin
         nxt_ovf0 = wr_data[dtc_pkg::RUN_OVF0_BIT];
         nxt_ovf1 = wr_data[dtc_pkg::RUN_OVF1_BIT];
      end
      if (int_ack_zero) begin
         nxt_ovf0 = 1'b0;                                                // see R16
      end
      if (int_ack_one) begin
         nxt_ovf1 = 1'b0;                                                // see R16
      end
      if (evt_ovf0) begin
         nxt_ovf0 = 1'b1;                                                // see R16
      end
      if (evt_ovf1) begin
         nxt_ovf1 = 1'b1;                                                // see R16
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ovf0_ff <= 1'b0;                                                // see R17
         ovf1_ff <= 1'b0;
      end else if (ce) begin
         ovf0_ff <= nxt_ovf0;
         ovf1_ff <= nxt_ovf1;
      end
   end

   // sticky interrupt status, write one to clear, set wins
   always_comb begin
      nxt_irq_stat = irq_stat_ff;
      if (wr_en && (addr == dtc_pkg::OFS_IRQ_STAT)) begin
         nxt_irq_stat = irq_stat_ff & ~wr_data[1:0];
      end
      nxt_irq_stat[dtc_pkg::IRQ_OVF0_BIT] = nxt_irq_stat[dtc_pkg::IRQ_OVF0_BIT] | evt_ovf0;
      nxt_irq_stat[dtc_pkg::IRQ_OVF1_BIT] = nxt_irq_stat[dtc_pkg::IRQ_OVF1_BIT] | evt_ovf1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_stat_ff <= dtc_pkg::RST_IRQ;
      end else if (ce) begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_mask_ff <= dtc_pkg::RST_IRQ;
      end else if (ce && wr_en && (addr == dtc_pkg::OFS_IRQ_MASK)) begin
         irq_mask_ff <= wr_data[1:0];
      end
   end

   // level interrupt, one cycle behind the status so it leaves a flop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else if (ce) begin
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // read decode; unmapped offsets read zero
   always_comb begin
      rd_mux = 8'h00;
      unique case (addr)
         dtc_pkg::OFS_MODE:     rd_mux = mode_ff;
         dtc_pkg::OFS_RUN: begin
            rd_mux[dtc_pkg::RUN_OVF1_BIT] = ovf1_ff;
            rd_mux[dtc_pkg::RUN_RUN1_BIT] = run1_ff;
            rd_mux[dtc_pkg::RUN_OVF0_BIT] = ovf0_ff;
            rd_mux[dtc_pkg::RUN_RUN0_BIT] = run0_ff;
         end
         dtc_pkg::OFS_LO_ZERO:  rd_mux = lo_ff[0];
         dtc_pkg::OFS_HI_ZERO:  rd_mux = hi_ff[0];
         dtc_pkg::OFS_LO_ONE:   rd_mux = lo_ff[1];
         dtc_pkg::OFS_HI_ONE:   rd_mux = hi_ff[1];
         dtc_pkg::OFS_IRQ_STAT: rd_mux = {6'h00, irq_stat_ff};
         dtc_pkg::OFS_IRQ_MASK: rd_mux = {6'h00, irq_mask_ff};
         default:               rd_mux = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data_ff <= 8'h00;
      end else if (ce) begin
         rd_data_ff <= rd_en ? rd_mux : 8'h00;
      end
   end

   assign rd_data            = rd_data_ff;
   assign overflow_flag_zero = ovf0_ff;
   assign overflow_flag_one  = ovf1_ff;
   assign irq                = irq_ff;

endmodule
`default_nettype wire

// ===== logic/dtc_pkg.sv
// constants and types shared by the dual timer/counter block
package dtc_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [3:0] OFS_MODE     = 4'h0;
   localparam logic [3:0] OFS_RUN      = 4'h1;
   localparam logic [3:0] OFS_LO_ZERO  = 4'h2;
   localparam logic [3:0] OFS_HI_ZERO  = 4'h3;
   localparam logic [3:0] OFS_LO_ONE   = 4'h4;
   localparam logic [3:0] OFS_HI_ONE   = 4'h5;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h6;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h7;

   // timer_mode_control layout: one nibble per timer
   localparam int NIB_T0    = 0;
   localparam int NIB_T1    = 4;
   localparam int FLD_MODE  = 0;
   localparam int FLD_SRC   = 2;
   localparam int FLD_GATE  = 3;

   // timer_run_control layout
   localparam int RUN_OVF1_BIT = 7;
   localparam int RUN_RUN1_BIT = 6;
   localparam int RUN_OVF0_BIT = 5;
   localparam int RUN_RUN0_BIT = 4;

   // interrupt status / mask layout
   localparam int IRQ_OVF0_BIT = 0;
   localparam int IRQ_OVF1_BIT = 1;

   // mode encodings
   typedef enum logic [1:0] {
      DTC_MODE_13    = 2'h0,
      DTC_MODE_16    = 2'h1,
      DTC_MODE_RLD   = 2'h2,
      DTC_MODE_SPLIT = 2'h3
   } dtc_mode_t;

   // machine cycle length in core clocks
   localparam int         MACH_W         = 4;
   localparam logic [3:0] MACH_CYCLE_CLK = 4'hC;
   localparam logic [3:0] MACH_LAST      = MACH_CYCLE_CLK - 4'h1;

   // 13-bit mode low byte keeps only 5 bits
   localparam logic [7:0] LOW13_MASK = 8'h1F;

   // reset values
   localparam logic [7:0] RST_MODE  = 8'h00;
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [1:0] RST_IRQ   = 2'h0;
   localparam logic [3:0] RST_MACH  = 4'h0;
   localparam logic [3:0] RST_PINS  = 4'h0;

endpackage

// ===== logic/dtc_cnt_if.sv
// per-timer count request between the top and its count qualifier
`timescale 1ns/1ps
`default_nettype none
interface dtc_cnt_if;
   logic mach_tick;
   logic run;
   logic gate_en;
   logic src_ext;
   logic count_pin_s;
   logic gate_pin_s;
   logic advance;

   modport ctl (
      output mach_tick,
      output run,
      output gate_en,
      output src_ext,
      output count_pin_s,
      output gate_pin_s,
      input  advance
   );

   modport unit (
      input  mach_tick,
      input  run,
      input  gate_en,
      input  src_ext,
      input  count_pin_s,
      input  gate_pin_s,
      output advance
   );
endinterface
`default_nettype wire

// ===== logic/dtc_sync.sv
// two-flop synchroniser for the external pins
`timescale 1ns/1ps
`default_nettype none
module dtc_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q       <= '0;
      end else if (ce) begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// ===== logic/dtc_cnt_gate.sv
// count qualifier: source select, gate and falling edge detection
`timescale 1ns/1ps
`default_nettype none
module dtc_cnt_gate (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   dtc_cnt_if.unit   u
);
   logic smp_ff;
   logic prev_ff;
   logic fell;
   logic gate_ok;

   // pin sampled once per machine cycle; an edge is seen across two samples
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         smp_ff  <= 1'b0;
         prev_ff <= 1'b0;
      end else if (ce && u.mach_tick) begin
         smp_ff  <= u.count_pin_s;
         prev_ff <= smp_ff;
      end
   end

   assign fell    = prev_ff & ~smp_ff;                // see R15
   assign gate_ok = ~u.gate_en | u.gate_pin_s;        // see R2

   // see R1, R3, R4
   assign u.advance = u.mach_tick & u.run & gate_ok & (u.src_ext ? fell : 1'b1);
endmodule
`default_nettype wire

// ===== test/dtc_props.sv
// port-level assertion checker for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module dtc_props (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       ce,
   input wire logic [3:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rd_data,
   input wire logic       count_pin_zero,
   input wire logic       count_pin_one,
   input wire logic       gate_pin_zero,
   input wire logic       gate_pin_one,
   input wire logic       int_ack_zero,
   input wire logic       int_ack_one,
   input wire logic       overflow_flag_zero,
   input wire logic       overflow_flag_one,
   input wire logic       irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] mach_ff;
   // mirror of the machine phase, so flag changes can be tied to ticks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mach_ff <= 4'h0;
      end else if (ce) begin
         mach_ff <= (mach_ff == 4'hB) ? 4'h0 : mach_ff + 4'h1;
      end
   end
   wire logic tick   = ce && mach_ff == 4'hB;
   wire logic run_wr = ce && wr_en && addr == 4'h1;

   a_reset_clears: assert property (
      $rose(rst_n) |-> !overflow_flag_zero && !overflow_flag_one && !irq && rd_data == 8'h00)
      else $error("state not cleared by reset");
   a_read_idle: assert property (ce && !rd_en |=> rd_data == 8'h00)
      else $error("read data outside a read");
   a_unmapped_read: assert property (ce && rd_en && addr[3] |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_run_low_nibble: assert property (
      ce && rd_en && addr == 4'h1 |=> rd_data[3:0] == 4'h0)
      else $error("run register low nibble not zero");
   a_mode_readback: assert property (
      ce && wr_en && addr == 4'h0 ##1 !wr_en ##1 ce && rd_en && !wr_en && addr == 4'h0
      |=> rd_data == $past(wr_data, 3))
      else $error("mode register readback wrong");
   a_flag0_rise_cause: assert property (
      $rose(overflow_flag_zero) |-> $past(tick) || $past(run_wr && wr_data[5]))
      else $error("flag zero set off a tick");
   a_flag1_rise_cause: assert property (
      $rose(overflow_flag_one) |-> $past(tick) || $past(run_wr && wr_data[7]))
      else $error("flag one set off a tick");
   a_ack0_clears: assert property (
      ce && int_ack_zero && !tick && !run_wr |=> !overflow_flag_zero)
      else $error("ack zero left flag set");
   a_ack1_clears: assert property (
      ce && int_ack_one && !tick && !run_wr |=> !overflow_flag_one)
      else $error("ack one left flag set");
endmodule
bind dtc_top dtc_props u_props (.clk, .rst_n, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
   .count_pin_zero, .count_pin_one, .gate_pin_zero, .gate_pin_one, .int_ack_zero, .int_ack_one,
   .overflow_flag_zero, .overflow_flag_one, .irq);
`default_nettype wire

// ===== test/dtc_pin_model.sv
// external pin source: count pulses and gate levels
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
   input  wire logic clk,
   output var  logic count_pin_zero,
   output var  logic count_pin_one,
   output var  logic gate_pin_zero,
   output var  logic gate_pin_one
);
   // three machine cycles per level: a fall needs up to 26 clocks to be counted,
   // so the count has landed before the next pulse or a read
   localparam int HOLD = 36;
   initial begin
      count_pin_zero = 1'b0;
      count_pin_one  = 1'b0;
      gate_pin_zero  = 1'b0;
      gate_pin_one   = 1'b0;
   end
   task automatic gate(input logic g0, input logic g1);
      @(posedge clk);
      gate_pin_zero <= g0;
      gate_pin_one  <= g1;
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk);
         count_pin_zero <= 1'b1;
         count_pin_one  <= 1'b1;
         repeat (HOLD) @(posedge clk);
         count_pin_zero <= 1'b0;
         count_pin_one  <= 1'b0;
         repeat (HOLD) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       ce = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic       int_ack_zero = 1'b0;
   logic       int_ack_one = 1'b0;
   logic [7:0] rd_data;
   logic [7:0] a;
   logic [7:0] b;
   logic [7:0] c;
   wire logic  count_pin_zero, count_pin_one, gate_pin_zero, gate_pin_one;
   wire logic  overflow_flag_zero, overflow_flag_one, irq;
   int         error_cnt = 0;
   int         cmp_count = 0;
   int         cyc = 0;

   always #12.5 clk = ~clk;
   dtc_pin_model P (.clk, .count_pin_zero, .count_pin_one, .gate_pin_zero, .gate_pin_one);
   dtc_top DUT (.clk, .rst_n, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
      .count_pin_zero, .count_pin_one, .gate_pin_zero, .gate_pin_one, .int_ack_zero,
      .int_ack_one, .overflow_flag_zero, .overflow_flag_one, .irq);

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= ad;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      // let the write settle before any output is looked at
      #1;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [7:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= ad;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic rdc(input logic [3:0] ad, input logic [7:0] exp);
      logic [7:0] d;
      rd(ad, d);
      chk(d, exp);
   endtask
   task automatic ack(input logic [1:0] k);
      @(posedge clk);
      int_ack_zero <= k[0];
      int_ack_one <= k[1];
      @(posedge clk);
      int_ack_zero <= 1'b0;
      int_ack_one <= 1'b0;
      #1;
   endtask
   // 120 clocks between the two reads always hold exactly 10 ticks
   task automatic span(input logic [3:0] ad);
      rd(ad, a);
      repeat (118) @(posedge clk);
      rd(ad, b);
   endtask

   task automatic t_reset;
      for (int i = 0; i < 10; i++) rdc(i[3:0], 8'h00);
      chk({5'h0, overflow_flag_zero, overflow_flag_one, irq}, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         wr(dtc_pkg::OFS_MODE, {4{m[1:0]}});
         rdc(dtc_pkg::OFS_MODE, {4{m[1:0]}});
      end
      $display("mode test done");
   endtask
   task automatic t_timer;
      wr(dtc_pkg::OFS_MODE, 8'h19);
      wr(dtc_pkg::OFS_RUN, 8'h10);
      P.gate(1'b0, 1'b0);
      repeat (4) @(posedge clk);
      span(dtc_pkg::OFS_LO_ZERO);
      chk(b, a);
      P.gate(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      span(dtc_pkg::OFS_LO_ZERO);
      chk(b - a, 8'h0A);
      // a write while the clock enable is low must be lost
      @(posedge clk) ce <= 1'b0;
      wr(dtc_pkg::OFS_MODE, 8'hFF);
      @(posedge clk) ce <= 1'b1;
      rdc(dtc_pkg::OFS_MODE, 8'h19);
      rdc(dtc_pkg::OFS_LO_ONE, 8'h00);
      wr(dtc_pkg::OFS_RUN, 8'h00);
      span(dtc_pkg::OFS_LO_ZERO);
      chk(b, a);
      $display("timer test done");
   endtask
   task automatic t_mode0;
      wr(dtc_pkg::OFS_MODE, 8'h00);
      wr(dtc_pkg::OFS_LO_ZERO, 8'hFF);
      rdc(dtc_pkg::OFS_LO_ZERO, 8'h1F);
      wr(dtc_pkg::OFS_HI_ZERO, 8'hFF);
      wr(dtc_pkg::OFS_RUN, 8'h10);
      repeat (14) @(posedge clk);
      // flag looked at before the stop write, which itself sets it
      chk({7'h0, overflow_flag_zero}, 8'h01);
      wr(dtc_pkg::OFS_RUN, 8'h20);
      rd(dtc_pkg::OFS_LO_ZERO, a);
      chk(a & 8'hE0, 8'h00);
      rdc(dtc_pkg::OFS_HI_ZERO, 8'h00);
      rdc(dtc_pkg::OFS_IRQ_STAT, 8'h01);
      chk({7'h0, irq}, 8'h00);
      wr(dtc_pkg::OFS_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk);
      chk({7'h0, irq}, 8'h01);
      wr(dtc_pkg::OFS_IRQ_STAT, 8'h01);
      repeat (2) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      ack(2'h1);
      chk({7'h0, overflow_flag_zero}, 8'h00);
      wr(dtc_pkg::OFS_RUN, 8'h80);
      chk({7'h0, overflow_flag_one}, 8'h01);
      ack(2'h2);
      chk({7'h0, overflow_flag_one}, 8'h00);
      $display("mode zero test done");
   endtask
   task automatic t_reload;
      wr(dtc_pkg::OFS_MODE, 8'h22);
      wr(dtc_pkg::OFS_HI_ZERO, 8'hF0);
      wr(dtc_pkg::OFS_LO_ZERO, 8'hFE);
      wr(dtc_pkg::OFS_RUN, 8'h10);
      repeat (60) @(posedge clk);
      chk({7'h0, overflow_flag_zero}, 8'h01);
      wr(dtc_pkg::OFS_RUN, 8'h20);
      rd(dtc_pkg::OFS_LO_ZERO, a);
      chk({7'h0, a >= 8'hF0}, 8'h01);
      rdc(dtc_pkg::OFS_HI_ZERO, 8'hF0);
      $display("reload test done");
   endtask
   task automatic t_split;
      wr(dtc_pkg::OFS_LO_ONE, 8'h55);
      wr(dtc_pkg::OFS_MODE, 8'h33);
      wr(dtc_pkg::OFS_LO_ZERO, 8'h00);
      wr(dtc_pkg::OFS_RUN, 8'h40);
      span(dtc_pkg::OFS_HI_ZERO);
      chk(b - a, 8'h0A);
      rdc(dtc_pkg::OFS_LO_ZERO, 8'h00);
      rdc(dtc_pkg::OFS_LO_ONE, 8'h55);
      wr(dtc_pkg::OFS_RUN, 8'h10);
      rd(dtc_pkg::OFS_HI_ZERO, c);
      span(dtc_pkg::OFS_LO_ZERO);
      chk(b - a, 8'h0A);
      rdc(dtc_pkg::OFS_HI_ZERO, c);
      wr(dtc_pkg::OFS_RUN, 8'h40);
      wr(dtc_pkg::OFS_HI_ZERO, 8'hFF);
      repeat (14) @(posedge clk);
      chk({6'h0, overflow_flag_one, overflow_flag_zero}, 8'h02);
      $display("split test done");
   endtask
   task automatic t_counter;
      wr(dtc_pkg::OFS_RUN, 8'h00);
      wr(dtc_pkg::OFS_MODE, 8'hDD);
      wr(dtc_pkg::OFS_LO_ZERO, 8'h00);
      wr(dtc_pkg::OFS_LO_ONE, 8'h00);
      wr(dtc_pkg::OFS_RUN, 8'h50);
      P.gate(1'b1, 1'b0);
      P.pulse(3);
      rdc(dtc_pkg::OFS_LO_ZERO, 8'h03);
      rdc(dtc_pkg::OFS_LO_ONE, 8'h00);
      P.gate(1'b0, 1'b1);
      P.pulse(2);
      rdc(dtc_pkg::OFS_LO_ZERO, 8'h03);
      rdc(dtc_pkg::OFS_LO_ONE, 8'h02);
      $display("counter test done");
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_modes();
      t_timer();
      t_mode0();
      t_reload();
      t_split();
      t_counter();
      give_verdict();
   end
endmodule
`default_nettype wire
